// File: sim/dac_loader_monitor.sv
// Purpose: Port checker of the serial word loader.
// Assumes: Pins move only just after i_clk rising edges.
// Notes:   Pin history is kept in three sample stages.
`timescale 1ns/1ps
`default_nettype none
`include "dac_loader_defs.svh"

module dac_loader_monitor
(
    // Clock and reset
    input wire logic                    i_clk,
    input wire logic                    i_arst_n,
    // Serial pins
    input wire logic                    i_cs_n,
    input wire logic                    i_frame_sync,
    input wire logic                    i_sclk,
    input wire logic                    i_din,
    // Loader outputs
    input wire logic [`DSWL_DATA_MSB:0] o_dac_code,
    input wire logic                    o_dac_update,
    input wire logic                    o_speed_select,
    input wire logic                    o_power_down_bit,
    input wire logic [`DSWL_REF_MSB:0]  o_reference_select,
    input wire logic                    o_internal_ref,
    input wire logic                    o_ref_high_range,
    input wire logic                    o_ctrl_update,
    input wire logic                    o_word_rejected,
    input wire logic                    o_busy
);
    // ****************************************************************
    // Pin history
    // ****************************************************************
    logic [2:0] p1;
    logic [2:0] p2;
    logic [2:0] p3;
    logic [5:0] ev;
    logic       fs_fall;
    logic       any_pulse;

    // Samples {cs_n, frame_sync, sclk}; ev marks recent rises
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            p1 <= 3'h0;
            p2 <= 3'h0;
            p3 <= 3'h0;
            ev <= 6'h00;
        end
        else
        begin
            p1 <= {i_cs_n, i_frame_sync, i_sclk};
            p2 <= p1;
            p3 <= p2;
            ev <= {ev[4:0], |(p1[1:0] & ~p2[1:0])};
        end
    end

    // Frame start seen at the pins, and any word outcome
    assign fs_fall   = p2[1] & ~p1[1];
    assign any_pulse = o_dac_update | o_ctrl_update | o_word_rejected;

    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);

    property p_reset_clear;
        $rose(i_arst_n) |-> o_dac_code == 12'h000 && !o_speed_select
            && !o_power_down_bit && o_reference_select == 2'h0 && !o_busy;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("outputs not cleared after reset");

    property p_start_busy;
        fs_fall && !p1[2] && !o_busy |-> ##[1:4] o_busy;
    endproperty
    a_start_busy: assert property (p_start_busy)
        else $error("frame start not taken");

    property p_deselect_idle;
        fs_fall && p1[2] && !o_busy |=> !o_busy [*4];
    endproperty
    a_deselect_idle: assert property (p_deselect_idle)
        else $error("frame start taken while deselected");

    property p_pulse_cs;
        o_dac_update || o_ctrl_update |-> !p3[2];
    endproperty
    a_pulse_cs: assert property (p_pulse_cs)
        else $error("write committed while deselected");

    property p_update_cause;
        any_pulse |-> |ev && !o_busy;
    endproperty
    a_update_cause: assert property (p_update_cause)
        else $error("word outcome without a clock or frame rise");

    property p_one_outcome;
        $onehot0({o_dac_update, o_ctrl_update, o_word_rejected})
            and (o_dac_update |=> !o_dac_update);
    endproperty
    a_one_outcome: assert property (p_one_outcome)
        else $error("outcome pulses overlap or stretch");

    property p_code_hold;
        $changed(o_dac_code) |-> o_dac_update;
    endproperty
    a_code_hold: assert property (p_code_hold)
        else $error("output code moved without a DAC write");

    property p_ref_hold;
        $changed(o_reference_select) |-> o_ctrl_update;
    endproperty
    a_ref_hold: assert property (p_ref_hold)
        else $error("reference moved without a control write");

    property p_prog_hold;
        $changed({o_speed_select, o_power_down_bit})
            |-> o_dac_update || o_ctrl_update;
    endproperty
    a_prog_hold: assert property (p_prog_hold)
        else $error("speed or power moved without a write");

    property p_ref_decode;
        o_internal_ref == (o_reference_select inside {2'h1, 2'h2})
            && o_ref_high_range == (o_reference_select == 2'h2);
    endproperty
    a_ref_decode: assert property (p_ref_decode)
        else $error("reference decode wrong");
endmodule : dac_loader_monitor

bind dac_serial_word_loader dac_loader_monitor u_mon
(
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_cs_n(i_cs_n),
    .i_frame_sync(i_frame_sync), .i_sclk(i_sclk), .i_din(i_din),
    .o_dac_code(o_dac_code), .o_dac_update(o_dac_update),
    .o_speed_select(o_speed_select), .o_busy(o_busy),
    .o_power_down_bit(o_power_down_bit),
    .o_reference_select(o_reference_select),
    .o_internal_ref(o_internal_ref), .o_ref_high_range(o_ref_high_range),
    .o_ctrl_update(o_ctrl_update), .o_word_rejected(o_word_rejected)
);
`default_nettype wire

// File: sim/host_port_model.sv
// Purpose: Host serial port that sends words to the loader.
// Assumes: Serial clock is 800 ns, idling high between frames.
// Notes:   mode 0 four-wire, 1 select tied low, 2 deselected, 3 abort.
`timescale 1ns/1ps
`default_nettype none

module host_port_model
(
    // Clock
    input  wire logic i_clk,
    // Serial pins
    output var  logic o_cs_n,
    output var  logic o_frame_sync,
    output var  logic o_sclk,
    output var  logic o_din
);
    // Idle pin levels
    initial
    begin
        o_cs_n       = 1'b1;
        o_frame_sync = 1'b1;
        o_sclk       = 1'b1;
        o_din        = 1'b0;
    end

    // Waits a number of clock edges
    task automatic hold(input int n);
        repeat (n) @(posedge i_clk);
    endtask : hold

    // Sends bits n-1..0 of w, MSB first, as two bytes when n is 16
    task automatic send_word(input logic [15:0] w, input int n,
                             input logic [1:0] mode);
        if (mode != 2'h2)
            o_cs_n <= 1'b0;
        hold(4);
        o_frame_sync <= 1'b0;
        hold(4);
        for (int i = n - 1; i >= 0; i--)
        begin
            o_din <= w[i];
            hold((i == 7) ? 8 : 4);
            o_sclk <= 1'b0;
            hold(4);
            if (mode == 2'h3 && i == 8)
                o_cs_n <= 1'b1;
            o_sclk <= 1'b1;
        end
        hold(4);
        o_frame_sync <= 1'b1;
        o_din        <= ~o_din;
        hold(4);
        if (mode != 2'h1)
            o_cs_n <= 1'b1;
        hold(4);
    endtask : send_word
endmodule : host_port_model
`default_nettype wire

// File: sim/tb_top.sv
// Purpose: Self-checking bench of the serial word loader.
// Assumes: 10 MHz clock; host model drives the pins.
// Notes:   Expected state is rebuilt from each word sent.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import dac_loader_pkg::*;

    logic        i_clk    = 1'b0;
    logic        i_arst_n = 1'b0;
    wire  logic  cs_n;
    wire  logic  fs;
    wire  logic  sclk;
    wire  logic  din;
    logic [11:0] o_dac_code;
    logic [1:0]  o_reference_select;
    logic        o_dac_update;
    logic        o_speed_select;
    logic        o_power_down_bit;
    logic        o_internal_ref;
    logic        o_ref_high_range;
    logic        o_ctrl_update;
    logic        o_word_rejected;
    logic        o_busy;
    int          errors    = 0;
    int          tests_run = 0;
    int          n_dac     = 0;
    int          n_ctl     = 0;
    int          n_rej     = 0;
    int          n_low     = 0;
    logic [15:0] seen;
    logic [11:0] e_code    = 12'h000;
    logic [1:0]  e_ref     = 2'h0;
    logic [1:0]  e_prog    = 2'h0;

    // Clock
    always #50 i_clk = ~i_clk;

    dac_serial_word_loader DUT
    (
        .i_clk(i_clk), .i_arst_n(i_arst_n), .i_cs_n(cs_n),
        .i_frame_sync(fs), .i_sclk(sclk), .i_din(din),
        .o_dac_code(o_dac_code), .o_dac_update(o_dac_update),
        .o_speed_select(o_speed_select), .o_busy(o_busy),
        .o_power_down_bit(o_power_down_bit),
        .o_reference_select(o_reference_select),
        .o_internal_ref(o_internal_ref), .o_ref_high_range(o_ref_high_range),
        .o_ctrl_update(o_ctrl_update), .o_word_rejected(o_word_rejected)
    );

    host_port_model host
    (
        .i_clk(i_clk), .o_cs_n(cs_n), .o_frame_sync(fs),
        .o_sclk(sclk), .o_din(din)
    );

    // Counts outcome pulses, and those seen before frame sync rises
    always @(posedge i_clk)
    begin
        n_dac += (o_dac_update === 1'b1);
        n_ctl += (o_ctrl_update === 1'b1);
        n_rej += (o_word_rejected === 1'b1);
        n_low += (fs === 1'b0) && (o_dac_update === 1'b1 ||
                 o_ctrl_update === 1'b1 || o_word_rejected === 1'b1);
    end

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic check(input logic [15:0] got, exp, input string what);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check

    task automatic complete_run();
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : complete_run

    // Sends one word and compares every output with the expectation
    task automatic run_word(input logic [15:0] w, input int n,
                            input logic [1:0] mode);
        int          k;
        int          b_dac;
        int          b_ctl;
        int          b_rej;
        int          b_low;
        logic [15:0] cw;
        logic [1:0]  sel;
        logic        hit;
        b_dac = n_dac;
        b_ctl = n_ctl;
        b_rej = n_rej;
        b_low = n_low;
        cw    = w & 16'((32'h1 << n) - 1);
        sel   = {cw[15], cw[12]};
        hit   = (mode < 2'h2) && (n > 0);
        host.send_word(w, n, mode);
        for (k = 0; k < 20 && o_busy !== 1'b0; k++)
            @(posedge i_clk);
        if (k == 20)
        begin
            errors++;
            $display("[FAIL] %0t busy stuck", $time);
            complete_run();
        end
        if (hit && sel inside {2'h0, 2'h3})
            e_prog = cw[14:13];
        if (hit && sel == 2'h0)
            e_code = cw[11:0];
        if (hit && sel == 2'h3)
            e_ref = cw[1:0];
        check(16'(n_dac - b_dac), 16'(hit && sel == 2'h0), "dac");
        check(16'(n_ctl - b_ctl), 16'(hit && sel == 2'h3), "ctl");
        check(16'(n_rej - b_rej), 16'(hit && ^sel), "rej");
        check(16'(n_low - b_low), 16'(hit && n == 16), "rise");
        check({4'h0, o_dac_code}, {4'h0, e_code}, "code");
        seen = {12'h0, o_speed_select, o_power_down_bit, o_reference_select};
        check(seen, {12'h0, e_prog, e_ref}, "ctrl");
        seen = {14'h0, o_internal_ref, o_ref_high_range};
        check(seen, {14'h0, ^e_ref, e_ref == 2'h2}, "ref");
    endtask : run_word

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        repeat (2) @(posedge i_clk);
        i_arst_n <= 1'b1;
        repeat (6) @(posedge i_clk);
        seen = {o_dac_code, o_speed_select, o_power_down_bit,
                o_reference_select};
        check(seen, 16'h0000, "reset");
        run_word(16'hD002, 16, 2'h0);
        run_word(16'h4FFF, 16, 2'h0);
        run_word(16'h0000, 16, 2'h0);
        run_word(16'hB001, 16, 2'h0);
        run_word(16'h9003, 16, 2'h0);
        run_word(16'h9000, 16, 2'h0);
        run_word(16'h8ABC, 16, 2'h0);
        run_word(16'h1ABC, 16, 2'h0);
        run_word(16'h0ABC, 12, 2'h0);
        run_word(16'h4555, 0, 2'h0);
        run_word(16'h4555, 16, 2'h2);
        run_word(16'h4555, 16, 2'h3);
        run_word(16'h2123, 16, 2'h1);
        run_word(16'h4321, 16, 2'h1);
        complete_run();
    end
endmodule : tb_top
`default_nettype wire

// File: verilog/dac_loader_defs.svh
// Purpose: Named constants of the serial word loader.
// Assumes: Included by the package and the loader modules.
// Notes:   Definitions only; no logic lives here.
`ifndef DAC_LOADER_DEFS_SVH
`define DAC_LOADER_DEFS_SVH

// ****************************************************************
// Word layout
// ****************************************************************
`define DSWL_WORD_BITS    16
`define DSWL_WORD_MSB     15
`define DSWL_DATA_BITS    12
`define DSWL_DATA_MSB     11
`define DSWL_BIT_SEL_HIGH 15
`define DSWL_BIT_SPEED    14
`define DSWL_BIT_POWER    13
`define DSWL_BIT_SEL_LOW  12
`define DSWL_REF_MSB      1
`define DSWL_REF_LSB      0

// ****************************************************************
// Register select and reference codes
// ****************************************************************
`define DSWL_SEL_DAC      2'h0
`define DSWL_SEL_CTRL     2'h3
`define DSWL_REF_EXT_A    2'h0
`define DSWL_REF_LOW      2'h1
`define DSWL_REF_HIGH     2'h2
`define DSWL_REF_EXT_B    2'h3

// ****************************************************************
// Bit counter
// ****************************************************************
`define DSWL_COUNT_BITS   5
`define DSWL_COUNT_ZERO   5'h00
`define DSWL_COUNT_ONE    5'h01
`define DSWL_COUNT_LAST   5'h10

// ****************************************************************
// Reset values and pin indices
// ****************************************************************
`define DSWL_RST_WORD     16'h0000
`define DSWL_RST_CODE     12'h000
`define DSWL_RST_REF      2'h0
`define DSWL_PIN_COUNT    4
`define DSWL_PIN_CS_N     0
`define DSWL_PIN_FRAME    1
`define DSWL_PIN_SCLK     2
`define DSWL_PIN_DIN      3

`endif

// File: verilog/dac_loader_pkg.sv
// Purpose: Types shared by the serial word loader.
// Assumes: dac_loader_defs.svh gives the widths.
// Notes:   State codes are fixed binary values.
`include "dac_loader_defs.svh"

package dac_loader_pkg;

    // ************************************************************
    // Word assembly states
    // ************************************************************
    typedef enum logic [1:0]
    {
        ST_IDLE      = 2'b00,
        ST_SHIFT     = 2'b01,
        ST_WAIT_RISE = 2'b10
    } link_state_type;

    // ************************************************************
    // Whole state of the loader
    // ************************************************************
    typedef struct packed
    {
        link_state_type                 state;
        logic [`DSWL_WORD_MSB:0]        shift;
        logic [`DSWL_COUNT_BITS-1:0]    count;
        logic [`DSWL_DATA_MSB:0]        dac_code;
        logic                           speed_select;
        logic                           power_down_bit;
        logic [`DSWL_REF_MSB:0]         reference_select;
        logic                           internal_ref;
        logic                           ref_high_range;
        logic                           dac_update;
        logic                           ctrl_update;
        logic                           word_rejected;
    } loader_state_type;

endpackage : dac_loader_pkg

// File: verilog/dac_serial_word_loader.sv
// Purpose: Serial input logic of a 12-bit DAC: assembles 16-bit words
//          and routes them to the DAC latch or the control register.
// Assumes: Serial clock is far slower than i_clk and is sampled by it.
// Notes:   Every output but o_busy comes from a flip-flop of the state struct; o_busy ORs the two state bits.
`timescale 1ns/1ps
`default_nettype none

`include "dac_loader_defs.svh"

// Notes on behaviour
// - Serial input is accepted only while chip select is held low.
// - Frame sync falling starts a word; bits taken on sclk falling, MSB first.
// - After sixteen bits or an early frame sync rise, the word is moved.
// - With sixteen bits sent, update comes on the next sclk rising edge.
// - The last word bit is taken on the sixteenth falling sclk edge.
// - Word holds four program bits on top and twelve data bits below.
// - Bit 14 is speed select: one is fast, zero is slow.
// - Bit 13 is power control: one powers down, zero is normal.
// - Select pair bits 15,12: 00 DAC, 11 control, others reserved.
// - A DAC write takes the twelve data bits as unsigned output code.
// - Reset clears every latch to zero.
// - Chip select tied low works; frame sync alone delimits words.
// - Control write: two low bits pick the reference, bits 14 and 13 set speed and power, others ignored.
// - Reference settings persist across later DAC writes; speed and power bits are rewritten by them.
module dac_serial_word_loader
    import dac_loader_pkg::*;
(
    // Clock and reset
    input  wire logic                       i_clk,
    input  wire logic                       i_arst_n,
    // Serial pins from the host
    input  wire logic                       i_cs_n,
    input  wire logic                       i_frame_sync,
    input  wire logic                       i_sclk,
    input  wire logic                       i_din,
    // DAC latch
    output var  logic [`DSWL_DATA_MSB:0]    o_dac_code,
    output var  logic                       o_dac_update,
    // Program bits
    output var  logic                       o_speed_select,
    output var  logic                       o_power_down_bit,
    // Reference control
    output var  logic [`DSWL_REF_MSB:0]     o_reference_select,
    output var  logic                       o_internal_ref,
    output var  logic                       o_ref_high_range,
    output var  logic                       o_ctrl_update,
    // Word status
    output var  logic                       o_word_rejected,
    output var  logic                       o_busy
);

    // ************************************************************
    // Pin synchronisation
    // ************************************************************

    logic [`DSWL_PIN_COUNT-1:0] pins;
    logic [`DSWL_PIN_COUNT-1:0] pin_level;
    logic [`DSWL_PIN_COUNT-1:0] pin_rise;
    logic [`DSWL_PIN_COUNT-1:0] pin_fall;

    // Gather the pins into one vector for the synchroniser
    always_comb
    begin
        pins                  = '0;
        pins[`DSWL_PIN_CS_N]  = i_cs_n;
        pins[`DSWL_PIN_FRAME] = i_frame_sync;
        pins[`DSWL_PIN_SCLK]  = i_sclk;
        pins[`DSWL_PIN_DIN]   = i_din;
    end

    // All four pins share the same latency, so data stays aligned
    pin_sync
    #(
        .WIDTH    (`DSWL_PIN_COUNT)
    )
    u_pin_sync
    (
        .i_clk    (i_clk),
        .i_arst_n (i_arst_n),
        .i_pin    (pins),
        .o_level  (pin_level),
        .o_rise   (pin_rise),
        .o_fall   (pin_fall)
    );

    // ************************************************************
    // Link events
    // ************************************************************

    logic selected;
    logic frame_start;
    logic frame_end;
    logic sclk_fall;
    logic sclk_rise;
    logic data_bit;

    // The synchroniser wakes up at zero, so idle-high pins show one
    // false rise after reset; rises only matter once a word is open
    // Chip select tied low keeps the part selected all the time
    assign selected    = ~pin_level[`DSWL_PIN_CS_N];
    assign frame_start = pin_fall[`DSWL_PIN_FRAME];
    assign frame_end   = pin_rise[`DSWL_PIN_FRAME];
    assign sclk_fall   = pin_fall[`DSWL_PIN_SCLK];
    assign sclk_rise   = pin_rise[`DSWL_PIN_SCLK];
    assign data_bit    = pin_level[`DSWL_PIN_DIN];

    // ************************************************************
    // State
    // ************************************************************

    loader_state_type st;
    loader_state_type next_st;

    // ************************************************************
    // Word commit
    // ************************************************************

    // Route a finished word to the DAC latch or the control register
    function automatic loader_state_type commit_word
    (
        input loader_state_type        cur,
        input logic [`DSWL_WORD_MSB:0] word
    );
        loader_state_type     res;
        logic [1:0]           sel;
        logic [`DSWL_REF_MSB:0] ref_bits;
        res      = cur;
        sel      = {word[`DSWL_BIT_SEL_HIGH],
                    word[`DSWL_BIT_SEL_LOW]};
        ref_bits = word[`DSWL_REF_MSB:`DSWL_REF_LSB];
        // Shift register is left alone; the next frame start clears it
        res.state = ST_IDLE;
        if (sel == `DSWL_SEL_DAC)
        begin
            // New unsigned output code and speed and power bits; reference bits keep their values
            res.dac_code       = word[`DSWL_DATA_MSB:0];
            res.speed_select   = word[`DSWL_BIT_SPEED];
            res.power_down_bit = word[`DSWL_BIT_POWER];
            res.dac_update     = 1'b1;
        end
        else if (sel == `DSWL_SEL_CTRL)
        begin
            // Only the two low data bits and the speed and power bits matter here
            res.reference_select = ref_bits;
            res.internal_ref     = (ref_bits == `DSWL_REF_LOW) ||
                                   (ref_bits == `DSWL_REF_HIGH);
            res.ref_high_range   = (ref_bits == `DSWL_REF_HIGH);
            res.speed_select     = word[`DSWL_BIT_SPEED];
            res.power_down_bit   = word[`DSWL_BIT_POWER];
            res.ctrl_update      = 1'b1;
        end
        else
        begin
            // Reserved code: nothing stored, only flagged
            // Such a word still closes the frame
            res.word_rejected = 1'b1;
        end
        return res;
    endfunction : commit_word

    // ************************************************************
    // Next-state logic
    // ************************************************************

    logic [`DSWL_WORD_MSB:0]     shifted;
    logic [`DSWL_COUNT_BITS-1:0] count_inc;

    // Bit shift and counter step
    // Five count bits hold sixteen without wrapping
    always_comb
    begin
        shifted   = {st.shift[`DSWL_WORD_MSB-1:0], data_bit};
        count_inc = st.count + `DSWL_COUNT_ONE;
    end

    // Word assembly; pulses last one cycle
    always_comb
    begin
        next_st               = st;
        next_st.dac_update    = 1'b0;
        next_st.ctrl_update   = 1'b0;
        next_st.word_rejected = 1'b0;
        unique case (st.state)
            ST_IDLE:
            begin
                // A frame only opens while the part is selected
                // Clock edges seen here are ignored
                if (selected && frame_start)
                begin
                    next_st.state = ST_SHIFT;
                    next_st.shift = `DSWL_RST_WORD;
                    next_st.count = `DSWL_COUNT_ZERO;
                end
            end
            ST_SHIFT:
            begin
                if (!selected)
                begin
                    // Deselect mid-word drops the partial word
                    next_st.state = ST_IDLE;
                end
                else if (frame_end)
                begin
                    // Early frame end moves what has arrived so far
                    // and beats a clock fall seen in the same sample
                    if (st.count != `DSWL_COUNT_ZERO)
                    begin
                        next_st = commit_word(st, st.shift);
                    end
                    else
                    begin
                        next_st.state = ST_IDLE;
                    end
                end
                else if (sclk_fall)
                begin
                    next_st.shift = shifted;
                    next_st.count = count_inc;
                    if (count_inc == `DSWL_COUNT_LAST)
                    begin
                        // Sixteenth falling edge took the last word bit
                        next_st.state = ST_WAIT_RISE;
                    end
                end
            end
            ST_WAIT_RISE:
            begin
                if (!selected)
                begin
                    next_st.state = ST_IDLE;
                end
                else if (sclk_rise || frame_end)
                begin
                    // Update on the first rising edge after the last bit
                    // Extra clock falls before that rise are ignored
                    next_st = commit_word(st, st.shift);
                end
            end
            default:
            begin
                next_st.state = ST_IDLE;
            end
        endcase
    end

    // ************************************************************
    // State register
    // ************************************************************

    // Reset clears every latch to zero
    // Pulses and the shift register restart clean as well
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            st.state            <= ST_IDLE;
            st.shift            <= `DSWL_RST_WORD;
            st.count            <= `DSWL_COUNT_ZERO;
            st.dac_code         <= `DSWL_RST_CODE;
            st.speed_select     <= 1'b0;
            st.power_down_bit   <= 1'b0;
            st.reference_select <= `DSWL_RST_REF;
            st.internal_ref     <= 1'b0;
            st.ref_high_range   <= 1'b0;
            st.dac_update       <= 1'b0;
            st.ctrl_update      <= 1'b0;
            st.word_rejected    <= 1'b0;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************

    // Straight from the state flip-flops
    // Each level output holds until the next matching write or reset
    assign o_dac_code         = st.dac_code;
    assign o_dac_update       = st.dac_update;
    assign o_speed_select     = st.speed_select;
    assign o_power_down_bit   = st.power_down_bit;
    assign o_reference_select = st.reference_select;
    assign o_internal_ref     = st.internal_ref;
    assign o_ref_high_range   = st.ref_high_range;
    assign o_ctrl_update      = st.ctrl_update;
    assign o_word_rejected    = st.word_rejected;

    // Busy while a word is being assembled
    // Any state but idle means a word is still open
    assign o_busy = st.state[0] | st.state[1];

endmodule : dac_serial_word_loader

`default_nettype wire

// File: verilog/pin_sync.sv
// Purpose: Two-stage synchroniser with edge detection for pin inputs.
// Assumes: Pins are asynchronous to i_clk.
// Notes:   Edges are judged from the second and third stages only.
`timescale 1ns/1ps
`default_nettype none

module pin_sync
#(
    parameter int WIDTH = 4
)
(
    // Clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_arst_n,
    // Raw pins
    input  wire logic [WIDTH-1:0] i_pin,
    // Synchronised level and edges
    output var  logic [WIDTH-1:0] o_level,
    output var  logic [WIDTH-1:0] o_rise,
    output var  logic [WIDTH-1:0] o_fall
);

    typedef struct packed
    {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] level;
        logic [WIDTH-1:0] last;
    } sync_state_type;

    sync_state_type st;
    sync_state_type next_st;

    // Shift each pin through the three stages
    always_comb
    begin
        next_st.meta  = i_pin;
        next_st.level = st.meta;
        next_st.last  = st.level;
    end

    // Register the stages
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    // Edges compare the stable stage with its delayed copy
    assign o_level = st.level;
    assign o_rise  = st.level & ~st.last;
    assign o_fall  = ~st.level & st.last;

endmodule : pin_sync

`default_nettype wire
